// ---- dv/cie_seq_model.sv ----
// Instruction sequencer model driving the entry unit's instruction port
module cie_seq_model
#(
    parameter logic [31:0] PC_VAL = 32'h0000_0100
)
(
    input wire logic CLK,
    output logic VALID,
    output logic [31:0] WORD,
    output logic [31:0] PC,
    output logic [31:0] NEXT_PC,
    output logic [31:0] EA,
    output logic [31:0] MT_DATA,
    output logic [1:0] SIZE,
    output logic [22:0] FLAGS
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet at time zero
    initial
    begin
        {VALID, WORD, PC, NEXT_PC, EA, MT_DATA, SIZE, FLAGS} = '0;
    end

    // One completion pulse; released lines other than NEXT_PC and SIZE flip so stale values show
    task automatic issue(input logic [31:0] w, input logic [31:0] a,
        input logic [31:0] m, input logic [1:0] s, input logic [22:0] f);
        @(posedge CLK);
        VALID <= 1'b1;
        WORD <= w;
        PC <= PC_VAL;
        NEXT_PC <= PC_VAL + 32'h4;
        EA <= a;
        MT_DATA <= m;
        SIZE <= s;
        FLAGS <= f;
        @(posedge CLK);
        VALID <= 1'b0;
        WORD <= ~w;
        PC <= ~PC_VAL;
        EA <= ~a;
        MT_DATA <= ~m;
        FLAGS <= ~f;
    endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench of the interrupt entry unit
`include "cie_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IPC = 32'h0000_4a10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] adr = 3'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, ipc, inpc, iea, imd, iw, vec, mso, r;
    logic [22:0] fl;
    logic [1:0] isz;
    logic [2:0] cause;
    logic wreq, vld, take, stop;
    int num_errors = 0;
    int compares = 0;

    // Free-running core clock, 4 ns
    always #2 clk = ~clk;

    // Byte lanes tied: every access is a whole word
    cie_entry dut_u
    (
        .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .INSN_VALID(vld),
        .INSN_WORD(iw), .INSN_PC(ipc), .INSN_NEXT_PC(inpc), .DATA_EA(iea),
        .ACC_SIZE(isz), .IS_FP_LDST(fl[0]), .IS_LDST_MULT(fl[1]),
        .IS_RESERVE(fl[2]), .IS_SCALAR_LDST(fl[3]), .IS_STRING(fl[4]),
        .IS_PRIV(fl[5]), .IS_SPR(fl[6]), .SPR_ON_CORE(fl[7]),
        .SPR_IMPL(fl[8]), .SPR_MSB(fl[9]), .IS_ILLEGAL(fl[10]),
        .IS_BRANCH(fl[11]), .IS_RFI(fl[12]), .IS_MTMSR(fl[13]),
        .IS_MTFPSCR(fl[14]), .MTMSR_DATA(imd), .IS_FP_ARITH(fl[15]),
        .FP_EXC_ENABLED(fl[16]), .FP_INTERMEDIATE(fl[17]),
        .FP_DENORM(fl[18]), .FP_SUMMARY(fl[19]), .FP_UNDERFLOW_EN(fl[20]),
        .BUS_ERR(fl[21]), .FETCH_ERR(fl[22]), .EXC_TAKE(take),
        .EXC_VECTOR(vec), .EXC_CAUSE(cause), .MSTATE_OUT(mso),
        .CHECKSTOP(stop)
    );

    cie_seq_model #(.PC_VAL(IPC)) seq_u
    (
        .CLK(clk), .VALID(vld), .WORD(iw), .PC(ipc), .NEXT_PC(inpc),
        .EA(iea), .MT_DATA(imd), .SIZE(isz), .FLAGS(fl)
    );

    task automatic print_verdict();
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for waitrequest low, sampled at the rising edge
    task automatic wait_ack();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0)
        begin
            num_errors++;
            $display("ERROR %0t bus access never answered", $time);
            print_verdict();
        end
    endtask

    task automatic bus_write(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_en <= 1'b1;
        wait_ack();
        wr_en <= 1'b0;
    endtask

    task automatic bus_read(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        adr <= a;
        rd_en <= 1'b1;
        wait_ack();
        d = rdat;
        rd_en <= 1'b0;
    endtask

    function automatic logic [31:0] vec_off(input logic [2:0] c);
        case (c)
            cie_pkg::CIE_MCHK: return `CIE_VEC_MCHK;
            cie_pkg::CIE_PRIV, cie_pkg::CIE_FPPROG: return `CIE_VEC_PROG;
            cie_pkg::CIE_ALIGN: return `CIE_VEC_ALIGN;
            cie_pkg::CIE_FPASSIST: return `CIE_VEC_FPA;
            cie_pkg::CIE_TRACE: return `CIE_VEC_TRACE;
            default: return `CIE_VEC_SWEMU;
        endcase
    endfunction

    // Set machine_state, complete one instruction, check the entry
    task automatic entry(input logic [2:0] c, input logic [31:0] m,
        input logic [22:0] f, input logic [1:0] s = 2'h2,
        input logic [31:0] a = 32'h0, input logic [31:0] w = 32'h8000_0000);
        logic [31:0] d;
        bus_write(`CIE_OFF_MSTATE, m);
        seq_u.issue(w, a, m, s, f);
        @(negedge clk);
        check_eq(take, {31'h0, c != 3'h0});
        if (c != 3'h0)
        begin
            check_eq(cause, c);
            d = m[`CIE_MS_VBASE] ? `CIE_BASE_HI : `CIE_BASE_LO;
            check_eq(vec, d | vec_off(c));
            check_eq(mso, (m & 32'h0000_1040) | m[16]);
            bus_read(`CIE_OFF_SPC, d);
            check_eq(d, (c == cie_pkg::CIE_TRACE) ? IPC + 32'h4 : IPC);
            bus_read(`CIE_OFF_SSTATE, d);
            check_eq(d, {1'b0, f[22], 14'h0, m[15:0]});
            bus_read(`CIE_OFF_STAT, d);
            check_eq(d, {29'h0, c});
        end
    endtask

    // Data-bus machine check: fault status fields and data address
    task automatic bus_mchk(input logic [31:0] m, input logic [31:0] w,
        input logic [31:0] a);
        logic x;
        logic [31:0] d;
        x = (w[31:26] == `CIE_XFORM_OPC);
        entry(cie_pkg::CIE_MCHK, m, 23'h200000, 2'h2, a, w);
        bus_read(`CIE_OFF_SFS, d);
        check_eq(d, {15'h0, x ? w[2:1] : 2'h0, x ? w[6] : w[26],
            x ? w[10:7] : w[30:27], w[25:16]});
        bus_read(`CIE_OFF_FDA, d);
        check_eq(d, a);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_eq(take, 32'h0);
        check_eq(stop, 32'h0);
        bus_read(`CIE_OFF_MSTATE, r);
        check_eq(r, `CIE_MSTATE_RST);
        bus_read(`CIE_OFF_CTRL, r);
        check_eq(r, `CIE_CTRL_RST);
        bus_write(`CIE_OFF_STAT, 32'hf);
        bus_read(`CIE_OFF_STAT, r);
        check_eq(r, 32'h0);
        bus_read(3'h7, r);
        check_eq(r, 32'h0);
        bus_mchk(32'h0001_10c3, 32'h9a5b_c3d8, 32'h0000_8a04);
        bus_mchk(32'h0000_1000, 32'h7c5a_b3ae, 32'h0000_4a0c);
        entry(cie_pkg::CIE_MCHK, 32'h1000, 23'h400000);
        entry(cie_pkg::CIE_MCHK, 32'h1000, 23'h200400);
        entry(cie_pkg::CIE_SWEMU, 32'h1000, 23'h400);
        entry(cie_pkg::CIE_SWEMU, 32'h5000, 23'h2c0);
        entry(cie_pkg::CIE_PRIV, 32'h5000, 23'h3c0);
        entry(cie_pkg::CIE_PRIV, 32'h5000, 23'h240);
        entry(cie_pkg::CIE_SWEMU, 32'h5000, 23'h40);
        entry(cie_pkg::CIE_PRIV, 32'h5000, 23'h20);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h20);
        entry(cie_pkg::CIE_ALIGN, 32'h1000, 23'h1, 2'h3, 32'h2);
        entry(cie_pkg::CIE_ALIGN, 32'h1000, 23'h2, 2'h2, 32'h1);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h2, 2'h2, 32'h8);
        entry(cie_pkg::CIE_ALIGN, 32'h1000, 23'h4, 2'h2, 32'h3);
        bus_write(`CIE_OFF_CTRL, 32'h1);
        entry(cie_pkg::CIE_ALIGN, 32'h1000, 23'h8, 2'h1, 32'h1);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h8, 2'h1, 32'h2);
        bus_write(`CIE_OFF_CTRL, 32'h0);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h8, 2'h2, 32'h2);
        entry(cie_pkg::CIE_ALIGN, 32'h0001_10c3, 23'h10);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h10);
        entry(cie_pkg::CIE_FPPROG, 32'h1800, 23'h84000);
        entry(cie_pkg::CIE_FPPROG, 32'h1100, 23'h82000);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h84000);
        entry(cie_pkg::CIE_FPASSIST, 32'h1800, 23'h98000);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h98000);
        entry(cie_pkg::CIE_FPASSIST, 32'h1000, 23'h28000);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h128000);
        entry(cie_pkg::CIE_FPASSIST, 32'h1000, 23'h48000);
        entry(cie_pkg::CIE_TRACE, 32'h1400, 23'h0);
        entry(cie_pkg::CIE_TRACE, 32'h1200, 23'h800);
        entry(cie_pkg::CIE_NONE, 32'h1200, 23'h0);
        // Return with single step on: no trace, low half from saved_state
        entry(cie_pkg::CIE_NONE, 32'h1400, 23'h1000);
        bus_read(`CIE_OFF_MSTATE, r);
        check_eq(r, 32'h0000_1200);
        entry(cie_pkg::CIE_SWEMU, 32'h1400, 23'h400);
        // Check enable off: bus error stops the core, later ones refused
        entry(cie_pkg::CIE_NONE, 32'h0, 23'h200000);
        check_eq(stop, 32'h1);
        entry(cie_pkg::CIE_NONE, 32'h1000, 23'h400);
        bus_read(`CIE_OFF_STAT, r);
        check_eq(r[3], 32'h1);
        print_verdict();
    end
endmodule

// ---- hw/cie_entry.sv ----
// Interrupt recognition, save-register update and vectoring of the core
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`include "cie_map.svh"

// Summary of operation
// RQ1 - Saved_state fetch flag marks fetch machine checks
// RQ2 - Entry clears fixed saved bits, copies machine_state
// RQ3 - Saved bit 30 only follows recoverable flag
// RQ4 - Entry keeps base/check enable, sets byte order
// RQ5 - Bus check fault status low bits, form bits
// RQ6 - Fault status bit 17 from form bit
// RQ7 - Fault status 18:21 from register field; code takes opcode bits 21:24 or 1:4
// RQ8 - Fault status 22:31 from instruction 6:15
// RQ9 - Fault address takes data effective address
// RQ10 - Machine check vectors to offset 0x200
// RQ11 - Storage interrupt vectors never raised by hardware
// RQ12 - Word misalignment of special accesses traps
// RQ13 - Misaligned scalar or swapped string traps
// RQ14 - Enabled fp summary on updates: program trap
// RQ15 - Fp arithmetic uses assist, not program trap
// RQ16 - Illegal instructions raise software emulation
// RQ17 - User-state privileged or protected register traps
// RQ18 - Single-step or branch trace after completion
// RQ19 - Trace saves next address, vectors 0xd00
// RQ20 - Fp assist for enabled, underflow, denormal cases
// RQ21 - Fp assist saves faulting address, vectors 0xe00
// RQ22 - Unimplemented special register raises emulation
// RQ23 - Software emulation vectors to offset 0x1000
// RQ24 - One interrupt per instruction by fixed priority
module cie_entry
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [2:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic INSN_VALID,
    input wire logic [31:0] INSN_WORD,
    input wire logic [31:0] INSN_PC,
    input wire logic [31:0] INSN_NEXT_PC,
    input wire logic [31:0] DATA_EA,
    input wire logic [1:0] ACC_SIZE,
    input wire logic IS_FP_LDST,
    input wire logic IS_LDST_MULT,
    input wire logic IS_RESERVE,
    input wire logic IS_SCALAR_LDST,
    input wire logic IS_STRING,
    input wire logic IS_PRIV,
    input wire logic IS_SPR,
    input wire logic SPR_ON_CORE,
    input wire logic SPR_IMPL,
    input wire logic SPR_MSB,
    input wire logic IS_ILLEGAL,
    input wire logic IS_BRANCH,
    input wire logic IS_RFI,
    input wire logic IS_MTMSR,
    input wire logic IS_MTFPSCR,
    input wire logic [31:0] MTMSR_DATA,
    input wire logic IS_FP_ARITH,
    input wire logic FP_EXC_ENABLED,
    input wire logic FP_INTERMEDIATE,
    input wire logic FP_DENORM,
    input wire logic FP_SUMMARY,
    input wire logic FP_UNDERFLOW_EN,
    input wire logic BUS_ERR,
    input wire logic FETCH_ERR,
    output logic EXC_TAKE,
    output logic [31:0] EXC_VECTOR,
    output logic [2:0] EXC_CAUSE,
    output logic [31:0] MSTATE_OUT,
    output logic CHECKSTOP
);
    logic [31:0] mstate_q, mstate_d;
    logic [31:0] sstate_q, sstate_d;
    logic [31:0] spc_q, spc_d;
    logic [31:0] sfs_q, sfs_d;
    logic [31:0] fda_q, fda_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q;
    logic wait_q;
    logic take_q;
    logic [31:0] vec_q;
    cie_pkg::cie_cause_e cause_q, cause_d;
    logic stop_q;

    // Byte-enable merge of a bus write into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (wd & m) | (old & ~m);
    endfunction

    // Offset from natural alignment; a dword is checked to word only
    function automatic logic misalign(input logic [1:0] ea,
        input logic [1:0] sz);
        return (sz == 2'h1) ? ea[0] : (sz != 2'h0) & (ea != 2'h0);
    endfunction

    // Instruction attributes
    wire fp_trap_mode = mstate_q[`CIE_MS_FP_HI] | mstate_q[`CIE_MS_FP_LO];
    wire user_mode = mstate_q[`CIE_MS_USER];
    wire is_xform = INSN_WORD[31:26] == `CIE_XFORM_OPC;
    wire word_mis = DATA_EA[1:0] != 2'h0;
    wire spr_missing = IS_SPR & ~SPR_IMPL;
    // Machine_state after a return or move, seen by the fp summary check
    wire [31:0] rfi_val = {mstate_q[31:16], sstate_q[15:0]};
    wire [31:0] upd_val = IS_RFI ? rfi_val : MTMSR_DATA;
    wire upd_trap = upd_val[`CIE_MS_FP_HI] | upd_val[`CIE_MS_FP_LO];

    // Condition decode, one wire per interrupt kind
    wire c_mchk = INSN_VALID & (BUS_ERR | FETCH_ERR);
    wire c_swemu = INSN_VALID & (IS_ILLEGAL // RQ16
        | (spr_missing & SPR_ON_CORE) // RQ22
        | (spr_missing & ~SPR_ON_CORE & (~SPR_MSB | ~user_mode))); // RQ22
    wire c_priv = INSN_VALID & user_mode & (IS_PRIV // RQ17
        | (IS_SPR & SPR_MSB & ~(spr_missing & SPR_ON_CORE))); // RQ17
    wire c_align = INSN_VALID & (
        ((IS_FP_LDST | IS_LDST_MULT | IS_RESERVE) & word_mis) // RQ12
        | (IS_SCALAR_LDST & ctrl_q[`CIE_CTRL_MISALIGN]
           & misalign(DATA_EA[1:0], ACC_SIZE)) // RQ13
        | ((IS_LDST_MULT | IS_STRING) & mstate_q[`CIE_MS_ORDER])); // RQ13
    // Only updates of the summary or trap mode give the program trap
    wire c_fpprog = INSN_VALID & ~IS_FP_ARITH & FP_SUMMARY // RQ14
        & (IS_MTFPSCR & fp_trap_mode | (IS_MTMSR | IS_RFI) & upd_trap);
    wire c_fpa = INSN_VALID & IS_FP_ARITH & ( // RQ15
        (FP_EXC_ENABLED & fp_trap_mode) // RQ20
        | (FP_INTERMEDIATE & ~FP_UNDERFLOW_EN) | FP_DENORM); // RQ20
    wire c_trace = INSN_VALID
        & ((mstate_q[`CIE_MS_STEP] & ~IS_RFI) // RQ18
        | (mstate_q[`CIE_MS_BR_TRACE] & IS_BRANCH)); // RQ18

    // Fixed priority; trace only when nothing else hit
    always_comb // RQ24
    begin
        cause_d = cie_pkg::CIE_NONE;
        if (c_mchk)
            cause_d = cie_pkg::CIE_MCHK;
        else if (c_swemu)
            cause_d = cie_pkg::CIE_SWEMU;
        else if (c_priv)
            cause_d = cie_pkg::CIE_PRIV;
        else if (c_align)
            cause_d = cie_pkg::CIE_ALIGN;
        else if (c_fpprog)
            cause_d = cie_pkg::CIE_FPPROG;
        else if (c_fpa)
            cause_d = cie_pkg::CIE_FPASSIST;
        else if (c_trace)
            cause_d = cie_pkg::CIE_TRACE; // RQ18
    end

    // A disabled machine check stops the core instead of vectoring
    wire mc_stop = cause_d == cie_pkg::CIE_MCHK
        & ~mstate_q[`CIE_MS_MC_EN];
    wire take = cause_d != cie_pkg::CIE_NONE & ~mc_stop & ~stop_q;
    wire bus_mc = take & cause_d == cie_pkg::CIE_MCHK & ~FETCH_ERR;
    wire [31:0] base = mstate_q[`CIE_MS_VBASE] ? `CIE_BASE_HI
        : `CIE_BASE_LO;
    // Storage vectors have no entry here: hardware never raises them
    logic [31:0] voff; // RQ11
    always_comb
    begin
        case (cause_d)
            cie_pkg::CIE_MCHK: voff = `CIE_VEC_MCHK; // RQ10
            cie_pkg::CIE_SWEMU: voff = `CIE_VEC_SWEMU; // RQ23
            cie_pkg::CIE_ALIGN: voff = `CIE_VEC_ALIGN;
            cie_pkg::CIE_TRACE: voff = `CIE_VEC_TRACE; // RQ19
            cie_pkg::CIE_FPASSIST: voff = `CIE_VEC_FPA; // RQ21
            default: voff = `CIE_VEC_PROG;
        endcase
    end

    // Entry images of the save registers
    logic [31:0] ss_entry;
    logic [31:0] ms_entry;
    logic [31:0] sfs_entry;
    always_comb
    begin
        ss_entry = 32'h0; // RQ2
        ss_entry[15:0] = mstate_q[15:0]; // RQ2 RQ3
        ss_entry[`CIE_SS_FETCH] = FETCH_ERR // RQ1
            & cause_d == cie_pkg::CIE_MCHK;
        ms_entry = 32'h0; // RQ4
        ms_entry[`CIE_MS_VBASE] = mstate_q[`CIE_MS_VBASE]; // RQ4
        ms_entry[`CIE_MS_MC_EN] = mstate_q[`CIE_MS_MC_EN]; // RQ4
        ms_entry[`CIE_MS_ORDER] = mstate_q[`CIE_MS_INT_ORDER]; // RQ4
        sfs_entry = 32'h0; // RQ5
        sfs_entry[16:15] = is_xform ? INSN_WORD[2:1] : 2'h0; // RQ5
        sfs_entry[14] = is_xform ? INSN_WORD[6] : INSN_WORD[26]; // RQ6
        sfs_entry[13:10] = is_xform ? INSN_WORD[10:7] // RQ7
            : INSN_WORD[30:27];
        sfs_entry[9:0] = INSN_WORD[25:16]; // RQ8
    end

    // Bus decode; a write lands on the edge that samples waitrequest low
    wire req = AVS_READ | AVS_WRITE;
    wire wr_go = AVS_WRITE & ~wait_q;
    wire wr_ms = wr_go & AVS_ADDRESS == `CIE_OFF_MSTATE;
    wire wr_ss = wr_go & AVS_ADDRESS == `CIE_OFF_SSTATE;
    wire wr_pc = wr_go & AVS_ADDRESS == `CIE_OFF_SPC;
    wire wr_sf = wr_go & AVS_ADDRESS == `CIE_OFF_SFS;
    wire wr_fa = wr_go & AVS_ADDRESS == `CIE_OFF_FDA;
    wire wr_ct = wr_go & AVS_ADDRESS == `CIE_OFF_CTRL;
    logic [31:0] rd_mux;
    always_comb
    begin
        case (AVS_ADDRESS)
            `CIE_OFF_MSTATE: rd_mux = mstate_q;
            `CIE_OFF_SSTATE: rd_mux = sstate_q;
            `CIE_OFF_SPC: rd_mux = spc_q;
            `CIE_OFF_SFS: rd_mux = sfs_q;
            `CIE_OFF_FDA: rd_mux = fda_q;
            `CIE_OFF_CTRL: rd_mux = ctrl_q;
            `CIE_OFF_STAT: rd_mux = {28'h0, stop_q, cause_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // Next values: hardware entry wins over a same-cycle bus write
    always_comb
    begin
        mstate_d = mstate_q;
        if (take)
            mstate_d = ms_entry; // RQ4
        else if (INSN_VALID & IS_RFI)
            mstate_d = rfi_val; // RQ3
        else if (INSN_VALID & IS_MTMSR)
            mstate_d = MTMSR_DATA;
        else if (wr_ms)
            mstate_d = merge(mstate_q, AVS_WRITEDATA, AVS_BYTEENABLE);
        sstate_d = take ? ss_entry // RQ2
            : wr_ss ? merge(sstate_q, AVS_WRITEDATA, AVS_BYTEENABLE)
            : sstate_q;
        spc_d = spc_q;
        if (take)
            spc_d = cause_d == cie_pkg::CIE_TRACE ? INSN_NEXT_PC // RQ19
                : INSN_PC; // RQ21
        else if (wr_pc)
            spc_d = merge(spc_q, AVS_WRITEDATA, AVS_BYTEENABLE);
        sfs_d = bus_mc ? sfs_entry // RQ5
            : wr_sf ? merge(sfs_q, AVS_WRITEDATA, AVS_BYTEENABLE) : sfs_q;
        fda_d = bus_mc ? DATA_EA // RQ9
            : wr_fa ? merge(fda_q, AVS_WRITEDATA, AVS_BYTEENABLE) : fda_q;
        ctrl_d = wr_ct ? merge(ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE)
            : ctrl_q;
    end

    // Architected registers
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            mstate_q <= `CIE_MSTATE_RST;
            sstate_q <= 32'h0;
            spc_q <= 32'h0;
            sfs_q <= 32'h0;
            fda_q <= 32'h0;
            ctrl_q <= `CIE_CTRL_RST;
        end
        else
        begin
            mstate_q <= mstate_d;
            sstate_q <= sstate_d;
            spc_q <= spc_d;
            sfs_q <= sfs_d;
            fda_q <= fda_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Entry report; checkstop holds until reset
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            take_q <= 1'b0;
            vec_q <= 32'h0;
            cause_q <= cie_pkg::CIE_NONE;
            stop_q <= 1'b0;
        end
        else
        begin
            take_q <= take; // RQ24
            if (take)
            begin
                vec_q <= base | voff;
                cause_q <= cause_d;
            end
            stop_q <= stop_q | (mc_stop & ~stop_q);
        end
    end

    // One wait cycle per request keeps read data a plain flop
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q)
                rdata_q <= rd_mux;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign EXC_TAKE = take_q;
    assign EXC_VECTOR = vec_q;
    assign EXC_CAUSE = cause_q;
    assign MSTATE_OUT = mstate_q;
    assign CHECKSTOP = stop_q;

    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    chk_mc_fetch_flag: assert property ( // RQ1
        take_q && cause_q == cie_pkg::CIE_MCHK
        |-> sstate_q[`CIE_SS_FETCH] == $past(FETCH_ERR))
        else $error("fetch flag wrong after machine check");
    chk_saved_state_copy: assert property ( // RQ2
        take_q |-> sstate_q[15:0] == $past(mstate_q[15:0])
        && sstate_q[29:27] == 3'h0 && sstate_q[21:16] == 6'h0)
        else $error("saved state image wrong on entry");
    chk_entry_mstate: assert property ( // RQ4
        take_q |-> mstate_q[`CIE_MS_ORDER] == $past(mstate_q[16])
        && mstate_q[`CIE_MS_VBASE] == $past(mstate_q[`CIE_MS_VBASE])
        && mstate_q[`CIE_MS_USER] == 1'b0)
        else $error("machine state wrong on entry");
    chk_fault_status_low: assert property ( // RQ8
        $past(bus_mc) |-> sfs_q[31:17] == 15'h0
        && sfs_q[9:0] == $past(INSN_WORD[25:16])
        && fda_q == $past(DATA_EA))
        else $error("fault status or address wrong");
    chk_trace_vector: assert property ( // RQ19
        take_q && cause_q == cie_pkg::CIE_TRACE
        |-> vec_q[15:0] == 16'h0d00 && spc_q == $past(INSN_NEXT_PC))
        else $error("trace entry wrong");
    chk_no_storage_vec: assert property ( // RQ11
        take_q |-> vec_q[15:0] != 16'h0300 && vec_q[15:0] != 16'h0400)
        else $error("storage vector raised");
    chk_illegal_emul: assert property ( // RQ16
        INSN_VALID && IS_ILLEGAL && !BUS_ERR && !FETCH_ERR && !stop_q
        |=> take_q && vec_q[15:0] == 16'h1000)
        else $error("illegal instruction not emulated");
    chk_mc_priority: assert property ( // RQ24
        c_mchk && mstate_q[`CIE_MS_MC_EN] && !stop_q
        |=> take_q && cause_q == cie_pkg::CIE_MCHK
        && vec_q[15:0] == 16'h0200)
        else $error("machine check lost priority");
    chk_rfi_no_trace: assert property ( // RQ18
        INSN_VALID && IS_RFI && !IS_BRANCH
        |=> !(take_q && cause_q == cie_pkg::CIE_TRACE))
        else $error("trace taken after return");
    chk_wait_single: assert property (
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for two cycles");
endmodule

// ---- hw/cie_map.svh ----
// Register offsets, field positions, vectors and resets of the entry unit
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

// Avalon word offsets
`define CIE_OFF_MSTATE 3'h0
`define CIE_OFF_SSTATE 3'h1
`define CIE_OFF_SPC 3'h2
`define CIE_OFF_SFS 3'h3
`define CIE_OFF_FDA 3'h4
`define CIE_OFF_CTRL 3'h5
`define CIE_OFF_STAT 3'h6

// Machine_state field positions (bit 0 is the LSB here)
`define CIE_MS_INT_ORDER 16
`define CIE_MS_USER 14
`define CIE_MS_MC_EN 12
`define CIE_MS_FP_HI 11
`define CIE_MS_STEP 10
`define CIE_MS_BR_TRACE 9
`define CIE_MS_FP_LO 8
`define CIE_MS_VBASE 6
`define CIE_MS_RECOV 1
`define CIE_MS_ORDER 0

// Saved_state fetch-error flag position
`define CIE_SS_FETCH 30

// Control register field
`define CIE_CTRL_MISALIGN 0

// Reset values
`define CIE_MSTATE_RST 32'h0000_1000
`define CIE_CTRL_RST 32'h0000_0000

// Vector bases and offsets
`define CIE_BASE_LO 32'h0000_0000
`define CIE_BASE_HI 32'hfff0_0000
`define CIE_VEC_MCHK 32'h0000_0200
`define CIE_VEC_DSI 32'h0000_0300
`define CIE_VEC_ISI 32'h0000_0400
`define CIE_VEC_ALIGN 32'h0000_0600
`define CIE_VEC_PROG 32'h0000_0700
`define CIE_VEC_TRACE 32'h0000_0d00
`define CIE_VEC_FPA 32'h0000_0e00
`define CIE_VEC_SWEMU 32'h0000_1000

// Primary opcode that marks the X-form load/store group
`define CIE_XFORM_OPC 6'h1f
`endif

// ---- hw/cie_pkg.sv ----
// Types shared by the interrupt entry unit
package cie_pkg;
    typedef enum logic [2:0]
    {
        CIE_NONE,
        CIE_MCHK,
        CIE_SWEMU,
        CIE_PRIV,
        CIE_ALIGN,
        CIE_FPPROG,
        CIE_FPASSIST,
        CIE_TRACE
    } cie_cause_e;
endpackage
